// File: src/hpm_pkg.sv
// Shared constants and types of the host and master port pin logic
package hpm_pkg;

  // Pending report counter
  localparam int REPORT_CNT_W = 8;
  localparam logic [REPORT_CNT_W-1:0] REPORT_CNT_RST = 8'h00;
  localparam logic [REPORT_CNT_W-1:0] REPORT_CNT_MAX = 8'hFF;

  // Strap settle: system cycles after reset release before the strap is taken
  localparam logic [2:0] STRAP_SETTLE_CYC = 3'h3;
  localparam logic [2:0] STRAP_SETTLE_RST = 3'h0;

  // General purpose pins
  localparam int GPIO_NUM = 5;
  localparam int GPIO_HSYNC_POS = 1;
  localparam int GPIO_VSYNC_POS = 2;

  // Host pin positions in the synchronised input vector
  localparam int HOST_PIN_NUM = 4;
  localparam int HOST_PIN_DATA = 0;
  localparam int HOST_PIN_CLOCK = 1;
  localparam int HOST_PIN_ADDR = 2;
  localparam int HOST_PIN_STRAP = 3;

  // Pin idle level held by the weak pull-ups
  localparam logic PIN_IDLE = 1'b1;

  // Host interface mode taken from the strap
  typedef enum logic {
    HOST_MODE_I2C,
    HOST_MODE_SPI
  } hpm_host_mode_t;

  // Strap capture sequence
  typedef enum logic {
    STRAP_WAIT,
    STRAP_LOCKED
  } hpm_strap_state_t;

  // Master port modes chosen for the renderer
  typedef enum logic [1:0] {
    MST_MODE_PARALLEL,
    MST_MODE_I2C,
    MST_MODE_SPI
  } hpm_mst_mode_t;

  // Renderer drive values for the master port, link clock domain
  typedef struct packed {
    logic [3:0] parallel_out;
    logic master_i2c_data_low;
    logic master_i2c_clock_low;
    logic master_spi_data_out;
    logic master_spi_clock_out;
    logic master_spi_select_n;
  } hpm_mst_drive_t;

  // General purpose pin configuration from the host
  typedef struct packed {
    logic [GPIO_NUM-1:0] dir_out;
    logic [GPIO_NUM-1:0] out_val;
    logic hsync_en;
    logic vsync_en;
  } hpm_gpio_cfg_t;

endpackage : hpm_pkg

// File: src/hpm_sync.sv
// Two flip-flop level synchroniser with a constant reset value
`timescale 1ns/1ps
module hpm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Destination clock and asynchronous reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Level from another domain or a pin
  input wire logic [WIDTH-1:0] d_i,
  // Synchronised level
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // First stage is read only by the second stage
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule : hpm_sync

// File: src/hpm_top.sv
// Host and master communication port pin function logic
`timescale 1ns/1ps
module hpm_top (
  // System clock, resets
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic HARDWARE_RESET_N_I,
  // Link clock of the master port renderer
  input wire logic CLK_LINK_I,
  // Report events from the protocol engine
  input wire logic REPORT_NEW_I,
  input wire logic REPORT_READ_I,
  output logic [hpm_pkg::REPORT_CNT_W-1:0] REPORT_PENDING_O,
  // Host interrupt pin, open drain
  output logic HOST_REPORT_IRQ_N_OUT_O,
  output logic HOST_REPORT_IRQ_N_OE_N_O,
  // Host data pin
  input wire logic HOST_I2C_DATA_PIN_I,
  output logic HOST_I2C_DATA_PIN_OUT_O,
  output logic HOST_I2C_DATA_PIN_OE_N_O,
  // Host clock pin
  input wire logic HOST_I2C_CLOCK_PIN_I,
  output logic HOST_I2C_CLOCK_PIN_OUT_O,
  output logic HOST_I2C_CLOCK_PIN_OE_N_O,
  // Host address select pin, input only
  input wire logic HOST_ADDRESS_SELECT_PIN_I,
  // Host interface strap pin
  input wire logic HOST_INTERFACE_STRAP_N_I,
  output logic HOST_INTERFACE_STRAP_N_OUT_O,
  output logic HOST_INTERFACE_STRAP_N_OE_N_O,
  // Slave protocol engine side
  input wire logic HOST_I2C_DATA_LOW_I,
  input wire logic HOST_I2C_CLOCK_LOW_I,
  input wire logic HOST_SPI_MISO_I,
  output logic HOST_MODE_VALID_O,
  output logic HOST_MODE_SPI_O,
  output logic HOST_I2C_DATA_O,
  output logic HOST_I2C_CLOCK_O,
  output logic HOST_ADDR_SEL_O,
  output logic HOST_SPI_SCK_O,
  output logic HOST_SPI_SELECT_N_O,
  output logic HOST_SPI_MOSI_O,
  // Master port configuration, system domain
  input wire hpm_pkg::hpm_mst_mode_t MASTER_MODE_I,
  output logic DRIVER_IRQ_IN_N_O,
  // Master port renderer, link domain
  input wire hpm_pkg::hpm_mst_drive_t MASTER_DRIVE_I,
  output logic MASTER_SPI_DATA_IN_O,
  // Master port pins, link domain
  input wire logic MASTER_PORT_PIN_TWO_I,
  output logic [3:0] MASTER_PORT_PIN_OUT_O,
  output logic [3:0] MASTER_PORT_PIN_OE_N_O,
  // General purpose pins
  input wire hpm_pkg::hpm_gpio_cfg_t GPIO_CFG_I,
  input wire logic [hpm_pkg::GPIO_NUM-1:0] GPIO_PIN_I,
  output logic [hpm_pkg::GPIO_NUM-1:0] GPIO_PIN_OUT_O,
  output logic [hpm_pkg::GPIO_NUM-1:0] GPIO_PIN_OE_N_O,
  output logic [hpm_pkg::GPIO_NUM-1:0] GPIO_IN_O,
  output logic HORIZONTAL_SYNC_IN_O,
  output logic EXTERNAL_FRAME_SYNC_IN_O
);

  logic [hpm_pkg::HOST_PIN_NUM-1:0] host_pin_s;
  logic [hpm_pkg::GPIO_NUM-1:0] gpio_s;
  logic mst_pin_two_sys_s;
  logic mst_pin_two_link_s;
  logic srst_link_s;
  logic [1:0] mst_mode_link_s;
  hpm_pkg::hpm_mst_mode_t mst_mode_link;
  hpm_pkg::hpm_strap_state_t strap_state_r;
  hpm_pkg::hpm_host_mode_t host_mode_r;
  logic [2:0] settle_cnt_r;
  logic [hpm_pkg::REPORT_CNT_W-1:0] report_cnt_r;
  logic [hpm_pkg::REPORT_CNT_W-1:0] report_cnt_nxt;
  logic irq_drive_r;
  logic locked;
  logic spi_sel;
  logic i2c_sel;
  logic [hpm_pkg::GPIO_NUM-1:0] gpio_forced_in;
  logic [3:0] mst_out_nxt;
  logic [3:0] mst_oe_n_nxt;
  logic [3:0] mst_out_r;
  logic [3:0] mst_oe_n_r;

  // Pin inputs into the system domain
  hpm_sync #(.WIDTH(hpm_pkg::HOST_PIN_NUM + hpm_pkg::GPIO_NUM + 1), .RST_VAL('1)) u_sync_sys (
    .clk_i(CLK_SYS_I),
    .arst_n_i(HARDWARE_RESET_N_I),
    .d_i({MASTER_PORT_PIN_TWO_I, GPIO_PIN_I, HOST_INTERFACE_STRAP_N_I,
          HOST_ADDRESS_SELECT_PIN_I, HOST_I2C_CLOCK_PIN_I, HOST_I2C_DATA_PIN_I}),
    .q_o({mst_pin_two_sys_s, gpio_s, host_pin_s})
  );

  // Reset, master mode and pin two into the link domain
  hpm_sync #(.WIDTH(4), .RST_VAL(4'hF)) u_sync_link (
    .clk_i(CLK_LINK_I),
    .arst_n_i(HARDWARE_RESET_N_I),
    .d_i({SRST_I, MASTER_MODE_I, MASTER_PORT_PIN_TWO_I}),
    .q_o({srst_link_s, mst_mode_link_s, mst_pin_two_link_s})
  );

  assign mst_mode_link = hpm_pkg::hpm_mst_mode_t'(mst_mode_link_s);
  assign locked = (strap_state_r == hpm_pkg::STRAP_LOCKED);
  assign spi_sel = locked && (host_mode_r == hpm_pkg::HOST_MODE_SPI);
  assign i2c_sel = locked && (host_mode_r == hpm_pkg::HOST_MODE_I2C);

  // Strap capture after reset release, then held
  always_ff @(posedge CLK_SYS_I or negedge HARDWARE_RESET_N_I) begin
    if (!HARDWARE_RESET_N_I) begin
      strap_state_r <= hpm_pkg::STRAP_WAIT;
      settle_cnt_r <= hpm_pkg::STRAP_SETTLE_RST;
      host_mode_r <= hpm_pkg::HOST_MODE_I2C;
    end else if (SRST_I) begin
      strap_state_r <= hpm_pkg::STRAP_WAIT;
      settle_cnt_r <= hpm_pkg::STRAP_SETTLE_RST;
      host_mode_r <= hpm_pkg::HOST_MODE_I2C;
    end else begin
      case (strap_state_r)
        hpm_pkg::STRAP_WAIT: begin
          if (settle_cnt_r == hpm_pkg::STRAP_SETTLE_CYC) begin
            host_mode_r <= host_pin_s[hpm_pkg::HOST_PIN_STRAP] ?
                           hpm_pkg::HOST_MODE_SPI : hpm_pkg::HOST_MODE_I2C;
            strap_state_r <= hpm_pkg::STRAP_LOCKED;
          end else begin
            settle_cnt_r <= settle_cnt_r + 3'h1;
          end
        end
        hpm_pkg::STRAP_LOCKED: begin
          strap_state_r <= hpm_pkg::STRAP_LOCKED;
        end
        default: begin
          strap_state_r <= hpm_pkg::STRAP_WAIT;
        end
      endcase
    end
  end

  // Next pending count; a new report and a read together cancel unless the count is zero, where it goes to one; a new one is lost only at REPORT_CNT_MAX
  always_comb begin
    report_cnt_nxt = report_cnt_r;
    case ({REPORT_NEW_I, REPORT_READ_I})
      2'b10: begin
        if (report_cnt_r != hpm_pkg::REPORT_CNT_MAX) begin
          report_cnt_nxt = report_cnt_r + 8'h01;
        end
      end
      2'b01: begin
        if (report_cnt_r != hpm_pkg::REPORT_CNT_RST) begin
          report_cnt_nxt = report_cnt_r - 8'h01;
        end
      end
      2'b11: begin
        if (report_cnt_r == hpm_pkg::REPORT_CNT_RST) begin
          report_cnt_nxt = report_cnt_r + 8'h01;
        end
      end
      default: begin
        report_cnt_nxt = report_cnt_r;
      end
    endcase
  end

  // Pending counter and interrupt drive
  always_ff @(posedge CLK_SYS_I or negedge HARDWARE_RESET_N_I) begin
    if (!HARDWARE_RESET_N_I) begin
      report_cnt_r <= hpm_pkg::REPORT_CNT_RST;
      irq_drive_r <= 1'b0;
    end else if (SRST_I) begin
      report_cnt_r <= hpm_pkg::REPORT_CNT_RST;
      irq_drive_r <= 1'b0;
    end else begin
      report_cnt_r <= report_cnt_nxt;
      irq_drive_r <= (report_cnt_nxt != hpm_pkg::REPORT_CNT_RST);
    end
  end

  // Interrupt pin only ever pulls low; the pull-up holds it otherwise
  assign HOST_REPORT_IRQ_N_OUT_O = 1'b0;
  assign HOST_REPORT_IRQ_N_OE_N_O = !irq_drive_r;
  assign REPORT_PENDING_O = report_cnt_r;

  // Host pin drives and decoded inputs for the protocol engine
  always_ff @(posedge CLK_SYS_I or negedge HARDWARE_RESET_N_I) begin
    if (!HARDWARE_RESET_N_I) begin
      HOST_I2C_DATA_PIN_OE_N_O <= 1'b1;
      HOST_I2C_CLOCK_PIN_OE_N_O <= 1'b1;
      HOST_INTERFACE_STRAP_N_OE_N_O <= 1'b1;
      HOST_INTERFACE_STRAP_N_OUT_O <= 1'b0;
      HOST_I2C_DATA_O <= hpm_pkg::PIN_IDLE;
      HOST_I2C_CLOCK_O <= hpm_pkg::PIN_IDLE;
      HOST_ADDR_SEL_O <= hpm_pkg::PIN_IDLE;
      HOST_SPI_SCK_O <= 1'b0;
      HOST_SPI_SELECT_N_O <= 1'b1;
      HOST_SPI_MOSI_O <= 1'b0;
    end else if (SRST_I) begin
      HOST_I2C_DATA_PIN_OE_N_O <= 1'b1;
      HOST_I2C_CLOCK_PIN_OE_N_O <= 1'b1;
      HOST_INTERFACE_STRAP_N_OE_N_O <= 1'b1;
      HOST_INTERFACE_STRAP_N_OUT_O <= 1'b0;
      HOST_I2C_DATA_O <= hpm_pkg::PIN_IDLE;
      HOST_I2C_CLOCK_O <= hpm_pkg::PIN_IDLE;
      HOST_ADDR_SEL_O <= hpm_pkg::PIN_IDLE;
      HOST_SPI_SCK_O <= 1'b0;
      HOST_SPI_SELECT_N_O <= 1'b1;
      HOST_SPI_MOSI_O <= 1'b0;
    end else begin
      HOST_I2C_DATA_PIN_OE_N_O <= !(i2c_sel && HOST_I2C_DATA_LOW_I);
      HOST_I2C_CLOCK_PIN_OE_N_O <= !(i2c_sel && HOST_I2C_CLOCK_LOW_I);
      HOST_INTERFACE_STRAP_N_OE_N_O <= !spi_sel;
      HOST_INTERFACE_STRAP_N_OUT_O <= spi_sel && HOST_SPI_MISO_I;
      HOST_I2C_DATA_O <= i2c_sel ? host_pin_s[hpm_pkg::HOST_PIN_DATA] : hpm_pkg::PIN_IDLE;
      HOST_I2C_CLOCK_O <= i2c_sel ? host_pin_s[hpm_pkg::HOST_PIN_CLOCK] : hpm_pkg::PIN_IDLE;
      HOST_ADDR_SEL_O <= i2c_sel ? host_pin_s[hpm_pkg::HOST_PIN_ADDR] : hpm_pkg::PIN_IDLE;
      HOST_SPI_SCK_O <= spi_sel && host_pin_s[hpm_pkg::HOST_PIN_DATA];
      HOST_SPI_SELECT_N_O <= spi_sel ? host_pin_s[hpm_pkg::HOST_PIN_CLOCK] : 1'b1;
      HOST_SPI_MOSI_O <= spi_sel && host_pin_s[hpm_pkg::HOST_PIN_ADDR];
    end
  end

  // Host data and clock pins drive a low only, as open drain
  assign HOST_I2C_DATA_PIN_OUT_O = 1'b0;
  assign HOST_I2C_CLOCK_PIN_OUT_O = 1'b0;
  assign HOST_MODE_VALID_O = locked;
  assign HOST_MODE_SPI_O = spi_sel;

  // Driver interrupt from master pin two, system domain
  always_ff @(posedge CLK_SYS_I or negedge HARDWARE_RESET_N_I) begin
    if (!HARDWARE_RESET_N_I) begin
      DRIVER_IRQ_IN_N_O <= 1'b1;
    end else if (SRST_I) begin
      DRIVER_IRQ_IN_N_O <= 1'b1;
    end else begin
      DRIVER_IRQ_IN_N_O <= (MASTER_MODE_I == hpm_pkg::MST_MODE_I2C) ?
                           mst_pin_two_sys_s : 1'b1;
    end
  end

  // Sync inputs that override the host's output choice
  always_comb begin
    gpio_forced_in = '0;
    gpio_forced_in[hpm_pkg::GPIO_HSYNC_POS] = GPIO_CFG_I.hsync_en;
    gpio_forced_in[hpm_pkg::GPIO_VSYNC_POS] = GPIO_CFG_I.vsync_en;
  end

  // General purpose pins, one slice each
  for (genvar g = 0; g < hpm_pkg::GPIO_NUM; g++) begin : g_gpio
    always_ff @(posedge CLK_SYS_I or negedge HARDWARE_RESET_N_I) begin
      if (!HARDWARE_RESET_N_I) begin
        GPIO_PIN_OUT_O[g] <= 1'b0;
        GPIO_PIN_OE_N_O[g] <= 1'b1;
        GPIO_IN_O[g] <= hpm_pkg::PIN_IDLE;
      end else if (SRST_I) begin
        GPIO_PIN_OUT_O[g] <= 1'b0;
        GPIO_PIN_OE_N_O[g] <= 1'b1;
        GPIO_IN_O[g] <= hpm_pkg::PIN_IDLE;
      end else begin
        GPIO_PIN_OUT_O[g] <= GPIO_CFG_I.out_val[g];
        GPIO_PIN_OE_N_O[g] <= !(GPIO_CFG_I.dir_out[g] && !gpio_forced_in[g]);
        GPIO_IN_O[g] <= gpio_s[g];
      end
    end
  end

  // Display sync inputs
  always_ff @(posedge CLK_SYS_I or negedge HARDWARE_RESET_N_I) begin
    if (!HARDWARE_RESET_N_I) begin
      HORIZONTAL_SYNC_IN_O <= 1'b0;
      EXTERNAL_FRAME_SYNC_IN_O <= 1'b0;
    end else if (SRST_I) begin
      HORIZONTAL_SYNC_IN_O <= 1'b0;
      EXTERNAL_FRAME_SYNC_IN_O <= 1'b0;
    end else begin
      HORIZONTAL_SYNC_IN_O <= GPIO_CFG_I.hsync_en && gpio_s[hpm_pkg::GPIO_HSYNC_POS];
      EXTERNAL_FRAME_SYNC_IN_O <= GPIO_CFG_I.vsync_en && gpio_s[hpm_pkg::GPIO_VSYNC_POS];
    end
  end

  // Master port pin function by renderer mode
  always_comb begin
    mst_out_nxt = 4'h0;
    mst_oe_n_nxt = 4'hF;
    case (mst_mode_link)
      hpm_pkg::MST_MODE_PARALLEL: begin
        mst_out_nxt = MASTER_DRIVE_I.parallel_out;
        mst_oe_n_nxt = 4'h0;
      end
      hpm_pkg::MST_MODE_I2C: begin
        mst_oe_n_nxt[0] = !MASTER_DRIVE_I.master_i2c_data_low;
        mst_oe_n_nxt[1] = !MASTER_DRIVE_I.master_i2c_clock_low;
      end
      hpm_pkg::MST_MODE_SPI: begin
        mst_out_nxt[0] = MASTER_DRIVE_I.master_spi_data_out;
        mst_out_nxt[1] = MASTER_DRIVE_I.master_spi_clock_out;
        mst_out_nxt[3] = MASTER_DRIVE_I.master_spi_select_n;
        mst_oe_n_nxt = 4'h4;
      end
      default: begin
        mst_out_nxt = 4'h0;
        mst_oe_n_nxt = 4'hF;
      end
    endcase
  end

  // Master port registers on the link clock
  always_ff @(posedge CLK_LINK_I or negedge HARDWARE_RESET_N_I) begin
    if (!HARDWARE_RESET_N_I) begin
      mst_out_r <= 4'h0;
      mst_oe_n_r <= 4'hF;
      MASTER_SPI_DATA_IN_O <= 1'b0;
    end else if (srst_link_s) begin
      mst_out_r <= 4'h0;
      mst_oe_n_r <= 4'hF;
      MASTER_SPI_DATA_IN_O <= 1'b0;
    end else begin
      mst_out_r <= mst_out_nxt;
      mst_oe_n_r <= mst_oe_n_nxt;
      MASTER_SPI_DATA_IN_O <= (mst_mode_link == hpm_pkg::MST_MODE_SPI) &&
                              mst_pin_two_link_s;
    end
  end

  assign MASTER_PORT_PIN_OUT_O = mst_out_r;
  assign MASTER_PORT_PIN_OE_N_O = mst_oe_n_r;

  // Checks on the system domain
  AST_IRQ_LOW: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (report_cnt_r != 8'h00) |-> !HOST_REPORT_IRQ_N_OE_N_O && !HOST_REPORT_IRQ_N_OUT_O)
    else $error("interrupt not asserted with reports pending");
  AST_IRQ_RELEASE: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (report_cnt_r == 8'h00) |-> HOST_REPORT_IRQ_N_OE_N_O)
    else $error("interrupt driven with no report pending");
  AST_LAST_READ: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (report_cnt_r == 8'h01 && REPORT_READ_I && !REPORT_NEW_I) |=>
    HOST_REPORT_IRQ_N_OE_N_O && (report_cnt_r == 8'h00))
    else $error("last read did not release interrupt");
  AST_READ_CONSUMES: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (report_cnt_r > 8'h01 && REPORT_READ_I && !REPORT_NEW_I) |=>
    !HOST_REPORT_IRQ_N_OE_N_O && (report_cnt_r == $past(report_cnt_r) - 8'h01))
    else $error("read did not consume exactly one report");
  AST_STRAP_TAKE: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    (strap_state_r == hpm_pkg::STRAP_WAIT && settle_cnt_r == hpm_pkg::STRAP_SETTLE_CYC) |=>
    locked && ((host_mode_r == hpm_pkg::HOST_MODE_SPI) == $past(host_pin_s[3])))
    else $error("strap level not captured as mode");
  AST_MODE_HELD: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    locked ##1 locked |-> $stable(host_mode_r))
    else $error("host mode changed while locked");
  AST_MISO_DRIVE: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    spi_sel ##1 spi_sel |-> !HOST_INTERFACE_STRAP_N_OE_N_O &&
    (HOST_INTERFACE_STRAP_N_OUT_O == $past(HOST_SPI_MISO_I)))
    else $error("strap pin not driving MISO in SPI mode");
  AST_SDA_SCK: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    spi_sel |=> HOST_I2C_DATA_PIN_OE_N_O && (HOST_SPI_SCK_O == $past(host_pin_s[0])))
    else $error("data pin wrong in SPI mode");
  AST_SEL_ADDR: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    i2c_sel |=> HOST_SPI_SELECT_N_O && (HOST_ADDR_SEL_O == $past(host_pin_s[2])))
    else $error("clock or address pin wrong in I2C mode");
  AST_SYNC_INPUT: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    GPIO_CFG_I.hsync_en |=> GPIO_PIN_OE_N_O[1])
    else $error("sync pin still driven");
  AST_AFTER_RESET: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    $rose(HARDWARE_RESET_N_I) |-> !locked && (report_cnt_r == 8'h00))
    else $error("state not reset by hardware reset");

  // Checks on the link domain
  AST_PARALLEL_OUT: assert property (@(posedge CLK_LINK_I) disable iff (srst_link_s)
    (mst_mode_link == hpm_pkg::MST_MODE_PARALLEL) |=>
    (MASTER_PORT_PIN_OE_N_O == 4'h0) &&
    (MASTER_PORT_PIN_OUT_O == $past(MASTER_DRIVE_I.parallel_out)))
    else $error("parallel outputs not on master pins");
  AST_SPI_PINS: assert property (@(posedge CLK_LINK_I) disable iff (srst_link_s)
    (mst_mode_link == hpm_pkg::MST_MODE_SPI) |=> (MASTER_PORT_PIN_OE_N_O == 4'h4) &&
    (MASTER_PORT_PIN_OUT_O[3] == $past(MASTER_DRIVE_I.master_spi_select_n)))
    else $error("master SPI pins wrong");
  AST_I2C_PINS: assert property (@(posedge CLK_LINK_I) disable iff (srst_link_s)
    (mst_mode_link == hpm_pkg::MST_MODE_I2C) |=> MASTER_PORT_PIN_OE_N_O[3] &&
    MASTER_PORT_PIN_OE_N_O[2] && (MASTER_PORT_PIN_OUT_O == 4'h0))
    else $error("master I2C pins wrong");

endmodule : hpm_top

// File: verification/hpm_host_model.sv
// Host processor model: resolved host pin wires and level-sensed interrupt
`timescale 1ns/1ps
module hpm_host_model (
  // Host side levels and strap termination
  input wire logic strap_high_i,
  input wire logic [2:0] host_lvl_i,
  // Device pin drivers
  input wire logic irq_out_i,
  input wire logic irq_oe_n_i,
  input wire logic data_out_i,
  input wire logic data_oe_n_i,
  input wire logic clock_out_i,
  input wire logic clock_oe_n_i,
  input wire logic strap_out_i,
  input wire logic strap_oe_n_i,
  // Resolved wires
  output logic data_w_o,
  output logic clock_w_o,
  output logic addr_w_o,
  output logic strap_w_o,
  output logic irq_pending_o
);
  // Pulled-up wires go low when either side pulls them down
  assign data_w_o = host_lvl_i[0] & (data_oe_n_i | data_out_i);
  assign clock_w_o = host_lvl_i[1] & (clock_oe_n_i | clock_out_i);
  assign addr_w_o = host_lvl_i[2];
  // Strap keeps its termination until the device drives it
  assign strap_w_o = strap_oe_n_i ? strap_high_i : strap_out_i;
  // Interrupt is taken by level, pull-up when released
  assign irq_pending_o = ~(irq_oe_n_i | irq_out_i);
endmodule : hpm_host_model

// File: verification/hpm_top_tb_top.sv
// Self-checking bench of the host and master port pin logic
`timescale 1ns/1ps
module hpm_top_tb_top;
  logic clk = 1'b0;
  logic clk_link = 1'b0;
  logic srst = 1'b1;
  logic hw_rst_n = 1'b0;
  logic rep_new = 1'b0;
  logic rep_read = 1'b0;
  logic strap_high = 1'b0;
  logic [2:0] host_lvl = 3'h7;
  logic eng_dlow = 1'b0;
  logic eng_clow = 1'b0;
  logic eng_miso = 1'b0;
  hpm_pkg::hpm_mst_mode_t mst_mode = hpm_pkg::MST_MODE_PARALLEL;
  hpm_pkg::hpm_mst_drive_t mst_drv = '0;
  logic pin_two = 1'b1;
  hpm_pkg::hpm_gpio_cfg_t gpio_cfg = '0;
  logic [4:0] gpio_pin = 5'h1F;
  logic [7:0] pending;
  logic irq_out, irq_oe_n, d_out, d_oe_n, c_out, c_oe_n, s_out, s_oe_n;
  logic m_valid, m_spi, i_dat, i_clk, a_sel, s_sck, s_sel_n, s_mosi, drv_irq_n, m_miso;
  logic [3:0] mst_out, mst_oe_n;
  logic [4:0] g_out, g_oe_n, g_in;
  logic hsync, esync, data_w, clock_w, addr_w, strap_w, irq_pend;
  logic [7:0] oe_exp [3] = '{8'h00, 8'h03, 8'h01};
  logic [7:0] lvl_exp [3] = '{8'h0A, 8'h0E, 8'h05};
  logic [7:0] in_exp [3] = '{8'h02, 8'h00, 8'h03};
  int num_errors = 0;
  int n_tests = 0;

  // System clock 4 ns, link clock 12 ns at an odd phase
  always #2 clk = ~clk;
  initial #1.3 forever #6 clk_link = ~clk_link;

  // Design under test
  hpm_top uut (
    .CLK_SYS_I(clk), .SRST_I(srst), .HARDWARE_RESET_N_I(hw_rst_n), .CLK_LINK_I(clk_link),
    .REPORT_NEW_I(rep_new), .REPORT_READ_I(rep_read), .REPORT_PENDING_O(pending),
    .HOST_REPORT_IRQ_N_OUT_O(irq_out), .HOST_REPORT_IRQ_N_OE_N_O(irq_oe_n),
    .HOST_I2C_DATA_PIN_I(data_w), .HOST_I2C_DATA_PIN_OUT_O(d_out),
    .HOST_I2C_DATA_PIN_OE_N_O(d_oe_n), .HOST_I2C_CLOCK_PIN_I(clock_w),
    .HOST_I2C_CLOCK_PIN_OUT_O(c_out), .HOST_I2C_CLOCK_PIN_OE_N_O(c_oe_n),
    .HOST_ADDRESS_SELECT_PIN_I(addr_w), .HOST_INTERFACE_STRAP_N_I(strap_w),
    .HOST_INTERFACE_STRAP_N_OUT_O(s_out), .HOST_INTERFACE_STRAP_N_OE_N_O(s_oe_n),
    .HOST_I2C_DATA_LOW_I(eng_dlow), .HOST_I2C_CLOCK_LOW_I(eng_clow),
    .HOST_SPI_MISO_I(eng_miso), .HOST_MODE_VALID_O(m_valid), .HOST_MODE_SPI_O(m_spi),
    .HOST_I2C_DATA_O(i_dat), .HOST_I2C_CLOCK_O(i_clk), .HOST_ADDR_SEL_O(a_sel),
    .HOST_SPI_SCK_O(s_sck), .HOST_SPI_SELECT_N_O(s_sel_n), .HOST_SPI_MOSI_O(s_mosi),
    .MASTER_MODE_I(mst_mode), .DRIVER_IRQ_IN_N_O(drv_irq_n), .MASTER_DRIVE_I(mst_drv),
    .MASTER_SPI_DATA_IN_O(m_miso), .MASTER_PORT_PIN_TWO_I(pin_two),
    .MASTER_PORT_PIN_OUT_O(mst_out), .MASTER_PORT_PIN_OE_N_O(mst_oe_n),
    .GPIO_CFG_I(gpio_cfg), .GPIO_PIN_I(gpio_pin), .GPIO_PIN_OUT_O(g_out),
    .GPIO_PIN_OE_N_O(g_oe_n), .GPIO_IN_O(g_in), .HORIZONTAL_SYNC_IN_O(hsync),
    .EXTERNAL_FRAME_SYNC_IN_O(esync)
  );

  // Host on the far side of the host pins
  hpm_host_model host (
    .strap_high_i(strap_high), .host_lvl_i(host_lvl), .irq_out_i(irq_out),
    .irq_oe_n_i(irq_oe_n), .data_out_i(d_out), .data_oe_n_i(d_oe_n), .clock_out_i(c_out),
    .clock_oe_n_i(c_oe_n), .strap_out_i(s_out), .strap_oe_n_i(s_oe_n), .data_w_o(data_w),
    .clock_w_o(clock_w), .addr_w_o(addr_w), .strap_w_o(strap_w), .irq_pending_o(irq_pend)
  );

  // Compare one value and count it
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Let n system edges pass, then settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Hold report new or read for n edges
  task automatic report(input logic nw, input logic rd, input int n);
    @(posedge clk);
    rep_new <= nw;
    rep_read <= rd;
    repeat (n) @(posedge clk);
    rep_new <= 1'b0;
    rep_read <= 1'b0;
    #1;
  endtask : report

  // Verdict and end of run
  task automatic wrap_up;
    $display("Checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // Hang guard
  initial begin
    #20000;
    num_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    chk("irq_rst", {7'h0, irq_oe_n}, 8'h01);
    srst <= 1'b0;
    hw_rst_n <= 1'b1;
    cyc(10);
    chk("mode_i2c", {6'h0, m_valid, m_spi}, 8'h02);
    report(1'b1, 1'b0, 3);
    chk("pend3", pending, 8'h03);
    chk("irq_low", {7'h0, irq_pend}, 8'h01);
    report(1'b0, 1'b1, 2);
    chk("irq_left", {7'h0, irq_pend}, 8'h01);
    report(1'b0, 1'b1, 1);
    chk("pend0", pending, 8'h00);
    chk("irq_free", {6'h0, irq_oe_n, irq_pend}, 8'h02);
    report(1'b0, 1'b1, 1);
    chk("pend_floor", pending, 8'h00);
    report(1'b1, 1'b1, 1);
    chk("pend_both", pending, 8'h01);
    // I2C host pins in both directions
    @(posedge clk) host_lvl <= 3'h0;
    cyc(4);
    chk("i2c_in", {5'h0, a_sel, i_clk, i_dat}, 8'h00);
    chk("spi_idle", {5'h0, s_sck, s_sel_n, s_mosi}, 8'h02);
    @(posedge clk) begin
      host_lvl <= 3'h7;
      eng_dlow <= 1'b1;
      eng_clow <= 1'b1;
      strap_high <= 1'b1;
    end
    cyc(10);
    chk("i2c_out", {4'h0, a_sel, data_w, clock_w, s_oe_n}, 8'h09);
    chk("mode_kept", {6'h0, m_valid, m_spi}, 8'h02);
    // Master port in each renderer mode
    @(posedge clk_link) mst_drv <= 9'h154;
    for (int m = 0; m < 3; m++) begin
      @(posedge clk) mst_mode <= hpm_pkg::hpm_mst_mode_t'(m);
      @(posedge clk_link) pin_two <= (m == 2);
      repeat (8) @(posedge clk_link);
      #1;
      chk("mst_oe_n", {6'h0, mst_oe_n[3:2]}, oe_exp[m]);
      chk("mst_lvl", {4'h0, mst_out | mst_oe_n}, lvl_exp[m]);
      chk("mst_in", {6'h0, drv_irq_n, m_miso}, in_exp[m]);
    end
    // General purpose pins and sync inputs
    @(posedge clk) begin
      gpio_cfg <= {5'h05, 5'h04, 1'b1, 1'b0};
      gpio_pin <= 5'h06;
    end
    cyc(4);
    chk("gpio_oe_n", {3'h0, g_oe_n}, 8'h1A);
    chk("gpio_out", {3'h0, g_out & 5'h05}, 8'h04);
    chk("gpio_in", {3'h0, g_in}, 8'h06);
    chk("sync_h", {6'h0, hsync, esync}, 8'h02);
    @(posedge clk) gpio_cfg <= {5'h05, 5'h04, 1'b0, 1'b1};
    cyc(4);
    chk("sync_v", {6'h0, hsync, esync}, 8'h01);
    chk("gpio_v_oe_n", {3'h0, g_oe_n}, 8'h1E);
    // Hardware reset mid-cycle, strap high now selects SPI
    report(1'b1, 1'b0, 1);
    @(posedge clk) begin
      host_lvl <= 3'h2;
      hw_rst_n <= 1'b0;
    end
    #1;
    chk("rst_pins", {irq_oe_n, d_oe_n, c_oe_n, s_oe_n, mst_oe_n}, 8'hFF);
    chk("rst_cnt", pending, 8'h00);
    repeat (3) @(posedge clk);
    hw_rst_n <= 1'b1;
    cyc(10);
    chk("mode_spi", {6'h0, m_valid, m_spi}, 8'h03);
    @(posedge clk) eng_miso <= 1'b1;
    cyc(2);
    chk("miso_hi", {6'h0, s_oe_n, strap_w}, 8'h01);
    @(posedge clk) begin
      eng_miso <= 1'b0;
      host_lvl <= 3'h5;
    end
    cyc(4);
    chk("miso_lo", {7'h0, strap_w}, 8'h00);
    chk("spi_in", {5'h0, s_sck, s_sel_n, s_mosi}, 8'h05);
    chk("i2c_idle", {4'h0, d_oe_n, a_sel, i_clk, i_dat}, 8'h0F);
    wrap_up();
  end
endmodule : hpm_top_tb_top
